//--- rtl/timer2_consts.svh
/*
  Register offsets, field positions, reset values and counts for the second general timer.
  Assumes byte addresses on a 32-bit Avalon-MM bus, one register per aligned word.
*/
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

`define OFS_CONTROL      8'hc8
`define OFS_MODE         8'hd0
`define OFS_MODE1        8'hd4
`define OFS_COUNT_LOW    8'hd8
`define OFS_COUNT_HIGH   8'hdc
`define OFS_RELOAD_LOW   8'he0
`define OFS_RELOAD_HIGH  8'he4

`define RST_CONTROL      8'h00
`define RST_MODE         8'h00
`define RST_MODE1        8'h00
`define RST_BYTE         8'h00

`define CTL_OVF          7
`define CTL_EXT          6
`define CTL_BANK_HI      5
`define CTL_BANK_LO      4
`define CTL_FALL_EN      3
`define CTL_HIGH_RUN     2
`define CTL_CLK0         1
`define CTL_CAP_RL       0

`define MOD_SPLIT        7
`define MOD_LCLK0        6
`define MOD_RISE_EN      5
`define MOD_CLK1         4
`define MOD_LOW_RUN      3
`define MOD_LRUN_CLR     2
`define MOD_CLKOUT_EN    1
`define MOD_MODE0        0

`define MOD1_LCLK1       7
`define MOD1_OVF_IGN     6
`define MOD1_BANK        5
`define MOD1_CLK2        4
`define MOD1_MODE1       3

`define DIV12_LAST       4'hb
`define BYTE_FULL        8'hff
`define WORD_FULL        16'hffff

`endif

//--- rtl/timer2_pkg.sv
/*
  Types shared by the second general timer.
  Assumes the constants header is compiled alongside it.
*/
package timer2_pkg;

   typedef logic [7:0] byte_t;

   typedef enum logic [2:0]
   {
      HSRC_DIV12   = 3'h0,
      HSRC_PIN     = 3'h1,
      HSRC_SYSTEM_CLOCK  = 3'h2,
      HSRC_EXTINT0 = 3'h3,
      HSRC_UART1   = 3'h4,
      HSRC_TIMER0  = 3'h5,
      HSRC_COMP0   = 3'h6,
      HSRC_KEYPAD  = 3'h7
   } hsrc_e;

   typedef enum logic [1:0]
   {
      LSRC_DIV12   = 2'h0,
      LSRC_SYSTEM_CLOCK  = 2'h1,
      LSRC_UART1   = 2'h2,
      LSRC_EXTINT0 = 2'h3
   } lsrc_e;

endpackage : timer2_pkg

//--- rtl/timer2_pwm_baud_clockout.sv
/*
  Second general timer: 16-bit and split counters, capture, auto-reload, split PWM,
  baud clocks for the serial port and a 50% clock output, behind an Avalon-MM slave.
  Assumes event inputs are one-cycle pulses on CORE_CLK and the two pins are asynchronous.
*/
// Chosen here: the Avalon-MM slave port.
// How it works
// - Split capture-with-auto-zero: two 8-bit counters, capture plus zero, three flags.
// - Split PWM: high count and high reload form the 8-bit period counter.
// - Split PWM: low count is compare value, low reload buffers new duty.
// - Split PWM: high overflow sets overflow flag and copies low reload to low count.
// - PWM drives the clock-out pin only while clock-output enable is set.
// - Transmit and receive select bits pick Timer 1 or this timer overflow.
// - Baud mode: high byte rollover reloads the full 16-bit counter.
// - While a serial select bit is set, 16-bit rollover sets no overflow flag.
// - In baud use an enabled external edge sets its flag without reload or capture.
// - Split baud: low byte is baud generator, high byte stays auto-reload timer.
// - Clock output gives 50% duty at counter clock over 2 x (65536 - reload).
// - Clock-output mode: each 16-bit overflow reloads both counter bytes.
// - Baud and clock output share one overflow rate, with no interrupt.
// - Split clock output toggles on low overflow, reloading from low reload.
// - Split: low overflow sets sticky low flag; interrupt only with its enable.
// - Control bits 5 and 4 are banked by the bank select bit.
// - Overflow flag set by hardware, cleared by software, interrupt can be ignored.
// - External flag set on enabled falling or rising edge, shares the interrupt.
// - Three-bit code picks counter clock; run bit drives high byte in split mode.
// - Capture/reload bit and mode bit 0 pick one of four modes.
`include "timer2_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module timer2_pwm_baud_clockout
   import timer2_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output var  logic [31:0] AVS_READDATA,
   output var  logic        AVS_WAITREQUEST,
   input  wire logic        COUNT_PIN,
   input  wire logic        EXT_TRIGGER_PIN,
   input  wire logic        EXTINT0_EVENT,
   input  wire logic        UART1_BAUD_OVERFLOW,
   input  wire logic        TIMER0_OVERFLOW,
   input  wire logic        COMPARATOR0_EVENT,
   input  wire logic        KEYPAD_EVENT,
   input  wire logic        TIMER1_OVERFLOW,
   output var  logic        CLKOUT_PIN,
   output var  logic        TX_BAUD_CLK,
   output var  logic        RX_BAUD_CLK,
   output var  logic        OVF_EVENT,
   output var  logic        TIMER_IRQ
);

   byte_t       ctrl_r;
   byte_t       mode_r;
   byte_t       mode1_r;
   byte_t       count_low_r;
   byte_t       count_high_r;
   byte_t       reload_low_r;
   byte_t       reload_high_r;
   logic        rx_baud_select_r;
   logic        tx_baud_select_r;
   logic        low_ovf_flag_r;
   logic        low_ovf_irq_enable_r;
   logic        wait_r;
   logic [31:0] rdata_r;
   logic [3:0]  div12_r;
   logic        toggle_r;
   logic        clkout_r;
   logic        tx_r;
   logic        rx_r;
   logic        ovf_ev_r;
   logic        irq_r;
   logic [1:0]  sync1_r;
   logic [1:0]  sync2_r;
   logic [1:0]  sync3_r;
   logic [1:0]  filt_r;
   logic [1:0]  prev_r;
   logic [1:0]  fall_w;
   logic [1:0]  rise_w;

   logic        wr_go;
   logic        rd_go;
   logic        split;
   logic        cap;
   logic        bit0;
   logic        pwm;
   logic        baud_any;
   logic        baud16;
   logic        clkout16;
   logic        tick12;
   logic        htick;
   logic        ltick;
   logic        edge_ev;
   logic        edge_act;
   logic        ov16;
   logic        ovh;
   logic        ovl;
   logic        ovf_ev;
   byte_t       wbyte;
   byte_t       ctrl_view;

   assign wbyte    = AVS_WRITEDATA[7:0];
   assign wr_go    = AVS_WRITE & ~wait_r & AVS_BYTEENABLE[0];
   assign rd_go    = AVS_READ & wait_r;
   assign split    = mode_r[`MOD_SPLIT];
   assign cap      = ctrl_r[`CTL_CAP_RL];
   assign bit0     = mode_r[`MOD_MODE0];
   assign pwm      = split & mode1_r[`MOD1_MODE1] & ~cap & ~bit0;
   assign baud_any = rx_baud_select_r | tx_baud_select_r;
   assign baud16   = ~split & baud_any;
   assign clkout16 = ~split & ~cap & mode_r[`MOD_CLKOUT_EN];
   assign tick12   = (div12_r == `DIV12_LAST);

   // Pins pass three flops; a level counts only once the second and third agree.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pin
         always_ff @(posedge CORE_CLK or posedge RST)
         begin
            if (RST)
            begin
               sync1_r[gi] <= 1'b1;
               sync2_r[gi] <= 1'b1;
               sync3_r[gi] <= 1'b1;
               filt_r[gi]  <= 1'b1;
               prev_r[gi]  <= 1'b1;
            end
            else
            begin
               sync1_r[gi] <= (gi == 0) ? COUNT_PIN : EXT_TRIGGER_PIN;
               sync2_r[gi] <= sync1_r[gi];
               sync3_r[gi] <= sync2_r[gi];
               if (sync2_r[gi] == sync3_r[gi])
                  filt_r[gi] <= sync3_r[gi];
               prev_r[gi]  <= filt_r[gi];
            end
         end
         assign fall_w[gi] = prev_r[gi] & ~filt_r[gi];
         assign rise_w[gi] = ~prev_r[gi] & filt_r[gi];
      end
   endgenerate

   assign edge_ev  = (fall_w[1] & ctrl_r[`CTL_FALL_EN]) | (rise_w[1] & mode_r[`MOD_RISE_EN]);
   // no reload or capture in baud use
   assign edge_act = edge_ev & ~baud_any;

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         div12_r <= 4'h0;
      else if (tick12)
         div12_r <= 4'h0;
      else
         div12_r <= div12_r + 4'h1;
   end

   // Low-byte overflow, needed by the high-byte source select in split mode.
   always_comb
   begin
      case (lsrc_e'({mode1_r[`MOD1_LCLK1], mode_r[`MOD_LCLK0]}))
         LSRC_DIV12:   ltick = tick12;
         LSRC_SYSTEM_CLOCK:  ltick = 1'b1;
         LSRC_UART1:   ltick = UART1_BAUD_OVERFLOW;
         LSRC_EXTINT0: ltick = EXTINT0_EVENT;
         default:      ltick = 1'b0;
      endcase
   end

   assign ovl = split & ~pwm & ctrl_low_run(mode_r) & ltick & (count_low_r == `BYTE_FULL);

   function automatic logic ctrl_low_run(input byte_t m);
      ctrl_low_run = m[`MOD_LOW_RUN];
   endfunction : ctrl_low_run

   always_comb
   begin
      case (hsrc_e'({mode1_r[`MOD1_CLK2], mode_r[`MOD_CLK1], ctrl_r[`CTL_CLK0]}))
         HSRC_DIV12:   htick = tick12;
         HSRC_PIN:     htick = fall_w[0];
         HSRC_SYSTEM_CLOCK:  htick = 1'b1;
         HSRC_EXTINT0: htick = split ? ovl : EXTINT0_EVENT;
         HSRC_UART1:   htick = UART1_BAUD_OVERFLOW;
         HSRC_TIMER0:  htick = TIMER0_OVERFLOW;
         HSRC_COMP0:   htick = COMPARATOR0_EVENT;
         HSRC_KEYPAD:  htick = KEYPAD_EVENT;
         default:      htick = 1'b0;
      endcase
   end

   assign ov16 = ~split & ctrl_r[`CTL_HIGH_RUN] & htick
                 & ({count_high_r, count_low_r} == `WORD_FULL);
   assign ovh  = split & ctrl_r[`CTL_HIGH_RUN] & htick & (count_high_r == `BYTE_FULL);
   assign ovf_ev = pwm ? ovh : (split ? ovl : ov16);

   // Avalon slave: every request waits one cycle, so decode and read data line up.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0;
      end
      else
      begin
         wait_r <= ~((AVS_READ | AVS_WRITE) & wait_r);
         if (rd_go)
         begin
            case (AVS_ADDRESS)
               `OFS_CONTROL:     rdata_r <= {24'h0, ctrl_view};
               `OFS_MODE:        rdata_r <= {24'h0, mode_r};
               `OFS_MODE1:       rdata_r <= {24'h0, mode1_r};
               `OFS_COUNT_LOW:   rdata_r <= {24'h0, count_low_r};
               `OFS_COUNT_HIGH:  rdata_r <= {24'h0, count_high_r};
               `OFS_RELOAD_LOW:  rdata_r <= {24'h0, reload_low_r};
               `OFS_RELOAD_HIGH: rdata_r <= {24'h0, reload_high_r};
               default:          rdata_r <= 32'h0;
            endcase
         end
      end
   end

   // banked view of bits 5 and 4
   always_comb
   begin
      ctrl_view = ctrl_r;
      if (mode1_r[`MOD1_BANK])
      begin
         ctrl_view[`CTL_BANK_HI] = low_ovf_flag_r;
         ctrl_view[`CTL_BANK_LO] = low_ovf_irq_enable_r;
      end
      else
      begin
         ctrl_view[`CTL_BANK_HI] = rx_baud_select_r;
         ctrl_view[`CTL_BANK_LO] = tx_baud_select_r;
      end
   end

   // Control register; hardware sets on the flags win over a software clear.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         ctrl_r <= `RST_CONTROL;
      else
      begin
         if (wr_go && AVS_ADDRESS == `OFS_CONTROL)
            ctrl_r <= {wbyte[7:6], 2'b00, wbyte[3:0]};
         if ((ov16 & ~baud_any) | ovh)
            ctrl_r[`CTL_OVF] <= 1'b1;
         if (edge_ev)
            ctrl_r[`CTL_EXT] <= 1'b1;
      end
   end

   // banked bits written through the control offset
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         rx_baud_select_r     <= 1'b0;
         tx_baud_select_r     <= 1'b0;
         low_ovf_flag_r       <= 1'b0;
         low_ovf_irq_enable_r <= 1'b0;
      end
      else
      begin
         if (wr_go && AVS_ADDRESS == `OFS_CONTROL)
         begin
            if (mode1_r[`MOD1_BANK])
            begin
               low_ovf_flag_r       <= wbyte[`CTL_BANK_HI];
               low_ovf_irq_enable_r <= wbyte[`CTL_BANK_LO];
            end
            else
            begin
               rx_baud_select_r <= wbyte[`CTL_BANK_HI];
               tx_baud_select_r <= wbyte[`CTL_BANK_LO];
            end
         end
         if (ovl)
            low_ovf_flag_r <= 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         mode_r  <= `RST_MODE;
         mode1_r <= `RST_MODE1;
      end
      else
      begin
         if (wr_go && AVS_ADDRESS == `OFS_MODE)
            mode_r <= wbyte;
         if (wr_go && AVS_ADDRESS == `OFS_MODE1)
            mode1_r <= {wbyte[7:3], 3'b000};
         // The low run bit may be stopped by a high overflow or a capture.
         if (mode_r[`MOD_LRUN_CLR] && ((ovh && !cap) || (edge_act && cap && split)))
            mode_r[`MOD_LOW_RUN] <= 1'b0;
      end
   end

   // Reload bytes: written by software, or loaded from the counter on capture.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         reload_low_r  <= `RST_BYTE;
         reload_high_r <= `RST_BYTE;
      end
      else
      begin
         // capture in split and 16-bit alike
         if (edge_act && cap)
         begin
            reload_low_r  <= count_low_r;
            reload_high_r <= count_high_r;
         end
         // low reload is the duty buffer
         if (wr_go && AVS_ADDRESS == `OFS_RELOAD_LOW)
            reload_low_r <= wbyte;
         if (wr_go && AVS_ADDRESS == `OFS_RELOAD_HIGH)
            reload_high_r <= wbyte;
      end
   end

   // High counter byte. Software writes take precedence, as they land on a stopped timer.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         count_high_r <= `RST_BYTE;
      else if (wr_go && AVS_ADDRESS == `OFS_COUNT_HIGH)
         count_high_r <= wbyte;
      else if (edge_act && cap && bit0)
         count_high_r <= 8'h00;
      else if (edge_act && !cap && bit0 && !pwm)
         count_high_r <= reload_high_r;
      else if (ov16)
         count_high_r <= cap && !baud16 ? 8'h00 : reload_high_r;
      else if (ovh)
         count_high_r <= cap ? 8'h00 : reload_high_r;
      else if (ctrl_r[`CTL_HIGH_RUN] && htick && (split || count_low_r == `BYTE_FULL))
         count_high_r <= count_high_r + 8'h01;
   end

   // Low counter byte.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         count_low_r <= `RST_BYTE;
      else if (wr_go && AVS_ADDRESS == `OFS_COUNT_LOW)
         count_low_r <= wbyte;
      else if (pwm)
      begin
         if (ovh)
            count_low_r <= reload_low_r;
      end
      else if (edge_act && cap && bit0)
         count_low_r <= 8'h00;
      else if (edge_act && !cap && bit0)
         count_low_r <= reload_low_r;
      else if (ov16)
         count_low_r <= cap && !baud16 ? 8'h00 : reload_low_r;
      // low byte as 8-bit baud generator
      else if (ovl)
         count_low_r <= cap ? 8'h00 : reload_low_r;
      else if (!split && ctrl_r[`CTL_HIGH_RUN] && htick)
         count_low_r <= count_low_r + 8'h01;
      else if (split && mode_r[`MOD_LOW_RUN] && ltick)
         count_low_r <= count_low_r + 8'h01;
   end

   // Clock output and serial clocks.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
      begin
         toggle_r <= 1'b0;
         clkout_r <= 1'b0;
         tx_r     <= 1'b0;
         rx_r     <= 1'b0;
         ovf_ev_r <= 1'b0;
      end
      else
      begin
         // toggle per overflow gives 50% duty
         if ((split && ovl) || (clkout16 && ov16))
            toggle_r <= ~toggle_r;
         if (pwm)
            clkout_r <= mode_r[`MOD_CLKOUT_EN] & (count_high_r < count_low_r);
         else
            clkout_r <= mode_r[`MOD_CLKOUT_EN] & (split | ~cap) & toggle_r;
         tx_r     <= tx_baud_select_r ? ovf_ev : TIMER1_OVERFLOW;
         rx_r     <= rx_baud_select_r ? ovf_ev : TIMER1_OVERFLOW;
         ovf_ev_r <= ovf_ev;
      end
   end

   // Shared interrupt request.
   always_ff @(posedge CORE_CLK or posedge RST)
   begin
      if (RST)
         irq_r <= 1'b0;
      else
      begin
         // low flag gated by its enable
         irq_r <= (ctrl_r[`CTL_OVF] & ~mode1_r[`MOD1_OVF_IGN] & ~clkout16)
                  | ctrl_r[`CTL_EXT]
                  | (low_ovf_flag_r & low_ovf_irq_enable_r);
      end
   end

   assign AVS_READDATA    = rdata_r;
   assign AVS_WAITREQUEST = wait_r;
   assign CLKOUT_PIN      = clkout_r;
   assign TX_BAUD_CLK     = tx_r;
   assign RX_BAUD_CLK     = rx_r;
   assign OVF_EVENT       = ovf_ev_r;
   assign TIMER_IRQ       = irq_r;

endmodule : timer2_pwm_baud_clockout

`default_nettype wire

//--- bench/timer2_checker_assertions.sv
/*
  Port checker for the second timer: bus handshake, baud clock sources, reset levels.
  Assumes it is bound to the timer top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module timer2_checker
(
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        TIMER1_OVERFLOW,
   input wire logic        CLKOUT_PIN,
   input wire logic        TX_BAUD_CLK,
   input wire logic        RX_BAUD_CLK,
   input wire logic        OVF_EVENT,
   input wire logic        TIMER_IRQ
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   logic rst_seen_r = 1'b0;
   always_ff @(posedge CORE_CLK) rst_seen_r <= RST;

   wait_ack_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("request not answered in the next cycle");
   ack_once_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");
   ack_cause_a: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
      else $error("answer without a request");
   rdata_zero_a: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
      else $error("upper read data not zero");
   rdata_hold_a: assert property (AVS_WAITREQUEST |-> $stable(AVS_READDATA))
      else $error("read data moved outside an answer");
   tx_source_a: assert property (TX_BAUD_CLK |-> $past(TIMER1_OVERFLOW) || OVF_EVENT)
      else $error("transmit baud pulse without a source");
   rx_source_a: assert property (RX_BAUD_CLK |-> $past(TIMER1_OVERFLOW) || OVF_EVENT)
      else $error("receive baud pulse without a source");
   reset_quiet_a: assert property (disable iff (1'b0)
      RST && rst_seen_r |-> AVS_WAITREQUEST && !TIMER_IRQ && !OVF_EVENT && !CLKOUT_PIN)
      else $error("outputs not at reset levels");

   wr_hs_c: cover property (AVS_WRITE && !AVS_WAITREQUEST);
   ovf_c: cover property (OVF_EVENT);
   tx_c: cover property (TX_BAUD_CLK && !$past(TIMER1_OVERFLOW));
   irq_c: cover property ($rose(TIMER_IRQ));
endmodule : timer2_checker

bind timer2_pwm_baud_clockout timer2_checker u_chk
(
   .CORE_CLK(CORE_CLK),
   .RST(RST),
   .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE),
   .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .TIMER1_OVERFLOW(TIMER1_OVERFLOW),
   .CLKOUT_PIN(CLKOUT_PIN),
   .TX_BAUD_CLK(TX_BAUD_CLK),
   .RX_BAUD_CLK(RX_BAUD_CLK),
   .OVF_EVENT(OVF_EVENT),
   .TIMER_IRQ(TIMER_IRQ)
);
`default_nettype wire

//--- bench/serial_far_end.sv
/*
  Far side of the timer: serial port baud inputs, a Timer 1 source and the clock-out pin.
  Assumes one clock; the counters are read by the bench through the hierarchy.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_far_end
(
   input  wire logic CORE_CLK,
   input  wire logic RST,
   input  wire logic TX_BAUD_CLK,
   input  wire logic RX_BAUD_CLK,
   input  wire logic CLKOUT_PIN,
   output var  logic TIMER1_OVERFLOW
);
   logic [3:0] div_r;
   logic       t1_d_r;
   logic       cko_d_r;
   int         tx_cnt;
   int         rx_bad;
   int         per;
   int         run_r;

   // Timer 1 runs free so the receive path always has pulses to pass through.
   always_ff @(posedge CORE_CLK or posedge RST)
      if (RST)
      begin
         div_r <= 4'h0;
         TIMER1_OVERFLOW <= 1'b0;
      end
      else
      begin
         div_r <= (div_r == 4'h9) ? 4'h0 : div_r + 4'h1;
         TIMER1_OVERFLOW <= (div_r == 4'h9);
      end

   always_ff @(posedge CORE_CLK or posedge RST)
      if (RST)
      begin
         t1_d_r <= 1'b0;
         cko_d_r <= 1'b0;
         tx_cnt <= 0;
         rx_bad <= 0;
         per <= 0;
         run_r <= 0;
      end
      else
      begin
         t1_d_r <= TIMER1_OVERFLOW;
         cko_d_r <= CLKOUT_PIN;
         tx_cnt <= tx_cnt + int'(TX_BAUD_CLK);
         rx_bad <= rx_bad + int'(RX_BAUD_CLK !== t1_d_r);
         run_r <= (CLKOUT_PIN && !cko_d_r) ? 1 : run_r + 1;
         if (CLKOUT_PIN && !cko_d_r)
            per <= run_r;
      end
endmodule : serial_far_end
`default_nettype wire

//--- bench/tb.sv
/*
  Self-checking bench for the second timer, one task per scenario.
  Assumes the constants header, the package, the far-side model and the checker.
*/
`include "timer2_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        clk;
   logic        rst;
   logic [7:0]  adr;
   logic        rd;
   logic        wr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        wreq;
   logic        cpin;
   logic        xpin;
   logic [7:3]  ev;
   logic        t1ov;
   logic        cko;
   logic        txc;
   logic        rxc;
   logic        ovf;
   logic        irq;
   int          err_total;
   int          compares;

   timer2_pwm_baud_clockout dut
   (
      .CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wreq), .COUNT_PIN(cpin), .EXT_TRIGGER_PIN(xpin),
      .EXTINT0_EVENT(ev[3]), .UART1_BAUD_OVERFLOW(ev[4]), .TIMER0_OVERFLOW(ev[5]),
      .COMPARATOR0_EVENT(ev[6]), .KEYPAD_EVENT(ev[7]), .TIMER1_OVERFLOW(t1ov),
      .CLKOUT_PIN(cko), .TX_BAUD_CLK(txc), .RX_BAUD_CLK(rxc), .OVF_EVENT(ovf),
      .TIMER_IRQ(irq)
   );

   serial_far_end far
   (
      .CORE_CLK(clk), .RST(rst), .TX_BAUD_CLK(txc), .RX_BAUD_CLK(rxc),
      .CLKOUT_PIN(cko), .TIMER1_OVERFLOW(t1ov)
   );

   always #12.5 clk = ~clk;

   task automatic stop_test;
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic hang;
      err_total++;
      $display("MISMATCH %0t wait ran out", $time);
      stop_test();
   endtask : hang

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
      end
   endtask : chk1

   task automatic chkn(input int got, input int exp);
      compares++;
      if (got != exp)
      begin
         err_total++;
         $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chkn

   // The request stays up until waitrequest is seen low; a spare edge keeps drivers apart.
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= {24'h0, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 40);
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
      if (n >= 40)
         hang();
   endtask : bus

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'b1, d, q);
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(a, 1'b0, 8'h00, q);
      chk8(q, exp);
   endtask : reg_rd

   task automatic hi_count(output int h);
      h = 0;
      repeat (64)
      begin
         @(posedge clk);
         h += int'(cko === 1'b1);
      end
   endtask : hi_count

   task automatic t_regs;
      reg_rd(`OFS_CONTROL, `RST_CONTROL);
      reg_rd(`OFS_MODE1, `RST_MODE1);
      reg_rd(8'hf0, 8'h00);
      reg_wr(`OFS_CONTROL, 8'h10);
      reg_rd(`OFS_CONTROL, 8'h10);
      reg_wr(`OFS_MODE1, 8'h20);
      reg_rd(`OFS_CONTROL, 8'h00);
      reg_wr(`OFS_CONTROL, 8'h30);
      reg_rd(`OFS_CONTROL, 8'h30);
      reg_wr(`OFS_CONTROL, 8'h00);
      reg_wr(`OFS_MODE1, 8'h00);
      reg_rd(`OFS_CONTROL, 8'h10);
      reg_wr(`OFS_CONTROL, 8'h00);
   endtask : t_regs

   task automatic t_src;
      int c;
      for (c = 1; c < 8; c++)
         if (c != 2)
         begin
            reg_wr(`OFS_MODE, {3'h0, c[1], 4'h0});
            reg_wr(`OFS_MODE1, {3'h0, c[2], 4'h0});
            reg_wr(`OFS_COUNT_LOW, 8'h00);
            reg_wr(`OFS_CONTROL, {6'h01, c[0], 1'b0});
            repeat (3)
               if (c == 1)
               begin
                  cpin <= 1'b0;
                  repeat (8) @(posedge clk);
                  cpin <= 1'b1;
                  repeat (8) @(posedge clk);
               end
               else
               begin
                  ev[c] <= 1'b1;
                  @(posedge clk);
                  ev[c] <= 1'b0;
                  repeat (3) @(posedge clk);
               end
            reg_wr(`OFS_CONTROL, 8'h00);
            reg_rd(`OFS_COUNT_LOW, 8'h03);
         end
   endtask : t_src

   task automatic t_ovf;
      int n;
      n = 0;
      reg_wr(`OFS_MODE, 8'h10);
      reg_wr(`OFS_MODE1, 8'h40);
      reg_wr(`OFS_RELOAD_HIGH, 8'h12);
      reg_wr(`OFS_RELOAD_LOW, 8'h34);
      reg_wr(`OFS_COUNT_HIGH, 8'hff);
      reg_wr(`OFS_COUNT_LOW, 8'hfe);
      reg_wr(`OFS_CONTROL, 8'h04);
      while (ovf !== 1'b1 && n < 30)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 30)
         hang();
      reg_wr(`OFS_CONTROL, 8'h80);
      reg_rd(`OFS_CONTROL, 8'h80);
      chk1(irq, 1'b0);
      reg_rd(`OFS_COUNT_HIGH, 8'h12);
      reg_wr(`OFS_MODE1, 8'h00);
      @(posedge clk);
      chk1(irq, 1'b1);
      reg_wr(`OFS_CONTROL, 8'h00);
      @(posedge clk);
      chk1(irq, 1'b0);
   endtask : t_ovf

   task automatic t_baud;
      int s;
      reg_wr(`OFS_MODE, 8'h10);
      reg_wr(`OFS_RELOAD_HIGH, 8'hff);
      reg_wr(`OFS_RELOAD_LOW, 8'hf0);
      reg_wr(`OFS_COUNT_HIGH, 8'hff);
      reg_wr(`OFS_COUNT_LOW, 8'hf0);
      reg_wr(`OFS_MODE, 8'h12);
      reg_wr(`OFS_CONTROL, 8'h14);
      repeat (80) @(posedge clk);
      s = far.tx_cnt;
      repeat (160) @(posedge clk);
      chkn(far.tx_cnt - s, 10);
      chkn(far.per, 32);
      chkn(far.rx_bad, 0);
      reg_rd(`OFS_CONTROL, 8'h14);
      chk1(irq, 1'b0);
      reg_wr(`OFS_CONTROL, 8'h1c);
      xpin <= 1'b0;
      repeat (12) @(posedge clk);
      reg_rd(`OFS_CONTROL, 8'h5c);
      chk1(irq, 1'b1);
      reg_wr(`OFS_CONTROL, 8'h00);
      xpin <= 1'b1;
   endtask : t_baud

   task automatic t_pwm;
      int h;
      reg_wr(`OFS_MODE1, 8'h08);
      reg_wr(`OFS_RELOAD_HIGH, 8'hf0);
      reg_wr(`OFS_COUNT_HIGH, 8'hf0);
      reg_wr(`OFS_RELOAD_LOW, 8'hf4);
      reg_wr(`OFS_COUNT_LOW, 8'hf4);
      reg_wr(`OFS_MODE, 8'h92);
      reg_wr(`OFS_CONTROL, 8'h04);
      repeat (40) @(posedge clk);
      hi_count(h);
      chkn(h, 16);
      reg_rd(`OFS_CONTROL, 8'h84);
      reg_wr(`OFS_RELOAD_LOW, 8'hf8);
      repeat (40) @(posedge clk);
      hi_count(h);
      chkn(h, 32);
      reg_wr(`OFS_MODE, 8'h90);
      hi_count(h);
      chkn(h, 0);
      reg_wr(`OFS_CONTROL, 8'h00);
      reg_wr(`OFS_CONTROL, 8'h00);
   endtask : t_pwm

   task automatic t_split;
      reg_wr(`OFS_MODE1, 8'h20);
      reg_wr(`OFS_MODE, 8'hc0);
      reg_wr(`OFS_RELOAD_LOW, 8'hf8);
      reg_wr(`OFS_COUNT_LOW, 8'hf8);
      reg_wr(`OFS_MODE, 8'hc2);
      reg_wr(`OFS_MODE, 8'hca);
      repeat (60) @(posedge clk);
      chkn(far.per, 16);
      reg_rd(`OFS_CONTROL, 8'h20);
      chk1(irq, 1'b0);
      reg_wr(`OFS_MODE, 8'h00);
      reg_wr(`OFS_CONTROL, 8'h00);
      reg_wr(`OFS_MODE1, 8'h00);
   endtask : t_split

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      adr = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdat = 32'h0;
      cpin = 1'b1;
      xpin = 1'b1;
      ev = 5'h00;
      err_total = 0;
      compares = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_src();
      t_ovf();
      t_baud();
      t_pwm();
      t_split();
      stop_test();
   end
endmodule : tb
`default_nettype wire
